//--- src/rtc_top.v
/*
  Oscillator control, calibration, alarm and watchdog logic of a backed-up
  real-time clock, reached over an asynchronous byte-wide memory bus.
  Assumes external clock counters present BCD time and take the reload and
  transfer pulses; nonvolatile images arrive on nv_* and are taken after reset.
*/
// What this block does
// - oscillator-disable bit is nonvolatile; 0 runs, 1 stops the oscillator
// - after re-enable the oscillator needs about 5 s, at most 10 s
// - at power-up, enabled but silent oscillator sets oscillator-failed flag
// - host checks oscillator-failed flag; writing 0 clears it
// - on failure reload base time; calibration and disable bit kept
// - five low bits are magnitude 0..31; bit 5 sign, 1 means faster
// - 64-minute cycle; one second per minute shortened 128 or lengthened 256
// - magnitude N affects only the first 2N minutes of the cycle
// - test bit toggles interrupt pin at 512 Hz, unaffected by calibration
// - date, hour, minute, second compared; match sets alarm flag
// - alarm register msb 0 includes the field, 1 excludes it
// - mask patterns give per-second, minute, hour, day or exact alarms
// - reading flags register clears alarm flag and all other flags
// - watchdog counts down at 32 Hz and stops with the oscillator
// - power-up copies timeout to counter; strobe reloads and restarts it
// - reaching zero sets watchdog flag; earlier strobe prevents it
// - timeout bits writable only while stored write-lock bit is 0
// - timeout value 0 disables the watchdog entirely
// - watchdog flag set on expiry, cleared by flags read, may interrupt
// - a flags read clears only on a complete read cycle with write enable high
// - times written under write-hold become base; clearing hold transfers
// - alarm interrupt enable routes match to the interrupt pin
`include "rtc_map.vh"

module rtc_top #(
  parameter CHK_CYC       = `RTC_OSC_CHK_CYC,
  parameter START_MAX_CYC = `RTC_OSC_START_CYC
) (
  input  wire        clk,
  input  wire        srst,
  input  wire [16:0] addr,
  input  wire [7:0]  dq_in,
  output reg  [7:0]  dq_out,
  output wire        dq_oe,
  input  wire        e_n,
  input  wire        w_n,
  input  wire        g_n,
  input  wire        osc_in,
  output wire        oscillator_disable,
  input  wire [7:0]  nv_cal,
  input  wire [7:0]  nv_wdog,
  output wire [7:0]  cal_image,
  input  wire [6:0]  time_sec,
  input  wire [6:0]  time_min,
  input  wire [6:0]  time_hour,
  input  wire [6:0]  time_date,
  output wire        sec_tick,
  output wire        upd_hold,
  output wire        write_hold,
  output reg         base_xfer,
  output reg         base_reload,
  output reg         int_out
);
  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  wire        e_s, w_s, g_s, osc_s;
  wire [16:0] addr_s;
  wire [7:0]  din_s;

  rtc_sync #(.W(28), .INIT({3'b111, 25'h0000000})) u_bus_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({e_n, w_n, g_n, addr, dq_in}),
    .q    ({e_s, w_s, g_s, addr_s, din_s})
  );

  rtc_sync #(.W(1), .INIT(1'b1)) u_osc_sync (
    .clk  (clk),
    .srst (srst),
    .d    (osc_in),
    .q    (osc_s)
  );

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  reg        osc_prev_q, load_q;
  reg        cyc_q, wr_q, rd_ok_q;
  reg [16:0] waddr_q;
  reg [7:0]  wdat_q;
  reg        wdf_q, af_q, oscillator_failed_flag_q, caltst_q, whold_q, rhold_q, whold_prev_q;
  reg [7:0]  cal_q;
  reg [5:0]  intr_q;
  reg [5:0]  wdt_q;
  reg        wdw_q;
  reg [5:0]  wd_cnt_q;
  reg [7:0]  alm_q [0:3];
  reg [27:0] chk_cnt_q;
  reg        chk_on_q;
  reg [7:0]  rdat;
  wire       osc_tick, tick32, tst_512;
  wire       cyc, wr, wr_end, rd_clr, strobe, wd_fire, alarm_hit, osc_fail;
  wire       hit, fld_s, fld_m, fld_h, fld_d;
  wire [5:0] wd_load;

  assign osc_tick = osc_s & ~osc_prev_q;

  rtc_prescale u_prescale (
    .clk      (clk),
    .srst     (srst),
    .osc_tick (osc_tick),
    .cal_sign (cal_q[`RTC_C_SIGN]),
    .cal_mag  (cal_q[4:0]),
    .sec_tick (sec_tick),
    .tick32   (tick32),
    .tst_512  (tst_512)
  );

  // ----------------------------------------------------------------------------
  // bus cycle tracking
  // ----------------------------------------------------------------------------
  assign cyc    = ~e_s;
  assign wr     = ~e_s & ~w_s;
  // a write commits when either strobe ends it
  assign wr_end = wr_q & ~wr;
  // a read clears flags only after a cycle that never saw write enable low
  assign rd_clr = cyc_q & ~cyc & rd_ok_q & (waddr_q == `RTC_A_FLAGS);

  always @(posedge clk) begin
    if (srst) begin
      osc_prev_q <= 1'b1; // a dead crystal stuck high must not look like an edge
      load_q     <= 1'b1;
      cyc_q      <= 1'b0;
      wr_q       <= 1'b0;
      rd_ok_q    <= 1'b0;
      waddr_q    <= 17'h00000;
      wdat_q     <= 8'h00;
    end else begin
      osc_prev_q <= osc_s;
      load_q     <= 1'b0;
      cyc_q      <= cyc;
      wr_q       <= wr;
      if (cyc) begin
        waddr_q <= addr_s;
        rd_ok_q <= (cyc_q ? rd_ok_q : 1'b1) & w_s;
      end
      if (wr)
        wdat_q <= din_s;
    end
  end

  // ----------------------------------------------------------------------------
  // read mux and output drive
  // ----------------------------------------------------------------------------
  assign hit = (addr_s >= `RTC_A_FLAGS) && (addr_s <= `RTC_A_CAL) &&
               (addr_s != `RTC_A_FLAGS + 17'h00001);
  assign dq_oe = cyc & w_s & ~g_s & hit;

  always @* begin
    case (addr_s)
      `RTC_A_FLAGS:    rdat = {wdf_q, af_q, 1'b0, oscillator_failed_flag_q, 1'b0, caltst_q, whold_q, rhold_q};
      `RTC_A_ALM_SEC:  rdat = alm_q[0];
      `RTC_A_ALM_MIN:  rdat = alm_q[1];
      `RTC_A_ALM_HR:   rdat = alm_q[2];
      `RTC_A_ALM_DATE: rdat = alm_q[3];
      `RTC_A_INTR:     rdat = {intr_q, 2'b00};
      `RTC_A_WDOG:     rdat = {1'b0, wdw_q, wdt_q}; // strobe reads back 0
      `RTC_A_CAL:      rdat = {cal_q[7], 1'b0, cal_q[5:0]};
      default:         rdat = 8'h00;
    endcase
  end

  // data is registered; it lags the address pins by the sync depth plus one clk
  always @(posedge clk) begin
    if (srst)
      dq_out <= 8'h00;
    else
      dq_out <= rdat;
  end

  // ----------------------------------------------------------------------------
  // register writes; nonvolatile images are taken once after reset
  // ----------------------------------------------------------------------------
  assign strobe  = wr_end && (waddr_q == `RTC_A_WDOG) && wdat_q[`RTC_W_STROBE];
  assign wd_load = wdw_q ? wdt_q : wdat_q[5:0];

  always @(posedge clk) begin
    if (srst) begin
      cal_q    <= 8'h00;
      intr_q   <= 6'h00;
      wdt_q    <= 6'h00;
      wdw_q    <= 1'b0;
      caltst_q <= 1'b0;
      whold_q  <= 1'b0;
      rhold_q  <= 1'b0;
      alm_q[0] <= 8'h00;
      alm_q[1] <= 8'h00;
      alm_q[2] <= 8'h00;
      alm_q[3] <= 8'h00;
    end else if (load_q) begin
      cal_q <= {nv_cal[7], 1'b0, nv_cal[5:0]};
      wdt_q <= nv_wdog[5:0];
      wdw_q <= nv_wdog[`RTC_W_LOCK];
    end else if (wr_end) begin
      case (waddr_q)
        `RTC_A_FLAGS: begin
          caltst_q <= wdat_q[`RTC_F_CAL];
          whold_q  <= wdat_q[`RTC_F_WHOLD];
          rhold_q  <= wdat_q[`RTC_F_RHOLD];
        end
        `RTC_A_WDOG: begin
          wdw_q <= wdat_q[`RTC_W_LOCK];
          if (!wdw_q)
            wdt_q <= wdat_q[5:0];
        end
        `RTC_A_CAL:      cal_q    <= {wdat_q[7], 1'b0, wdat_q[5:0]};
        `RTC_A_INTR:     intr_q   <= wdat_q[7:2];
        `RTC_A_ALM_SEC:  alm_q[0] <= wdat_q;
        `RTC_A_ALM_MIN:  alm_q[1] <= wdat_q;
        `RTC_A_ALM_HR:   alm_q[2] <= wdat_q;
        `RTC_A_ALM_DATE: alm_q[3] <= wdat_q;
        default: ;
      endcase
    end
  end

  // the oscillator failure path never touches the calibration register
  assign oscillator_disable = cal_q[`RTC_C_OSCDIS];
  assign cal_image          = cal_q;
  assign upd_hold           = rhold_q;
  assign write_hold         = whold_q;

  // ----------------------------------------------------------------------------
  // base time transfer when the write hold drops
  // ----------------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      whold_prev_q <= 1'b0;
      base_xfer    <= 1'b0;
    end else begin
      whold_prev_q <= whold_q;
      base_xfer    <= whold_prev_q & ~whold_q;
    end
  end

  // ----------------------------------------------------------------------------
  // oscillator activity check: short window at power-up, start-up window after
  // re-enable; any rising oscillator edge ends the check
  // ----------------------------------------------------------------------------
  assign osc_fail = chk_on_q && (chk_cnt_q == 28'h0000000) && !cal_q[`RTC_C_OSCDIS];

  always @(posedge clk) begin
    if (srst) begin
      chk_cnt_q   <= 28'h0000000;
      chk_on_q    <= 1'b0;
      base_reload <= 1'b0;
    end else begin
      base_reload <= osc_fail;
      if (load_q) begin
        chk_on_q  <= 1'b1;
        chk_cnt_q <= CHK_CYC[27:0];
      end else if (wr_end && (waddr_q == `RTC_A_CAL) && cal_q[`RTC_C_OSCDIS] &&
                   !wdat_q[`RTC_C_OSCDIS]) begin
        // a cold crystal may stay silent up to the start-up limit
        chk_on_q  <= 1'b1;
        chk_cnt_q <= START_MAX_CYC[27:0];
      end else if (osc_tick || cal_q[`RTC_C_OSCDIS] || chk_cnt_q == 28'h0000000) begin
        chk_on_q <= 1'b0;
      end else begin
        chk_cnt_q <= chk_cnt_q - 28'h0000001;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // watchdog: 32 Hz ticks only exist while the oscillator runs
  // ----------------------------------------------------------------------------
  assign wd_fire = tick32 && (wd_cnt_q == 6'h01) && (wdt_q != 6'h00) && !strobe;

  always @(posedge clk) begin
    if (srst)
      wd_cnt_q <= 6'h00;
    else if (load_q)
      wd_cnt_q <= nv_wdog[5:0];
    else if (strobe)
      wd_cnt_q <= wd_load;
    else if (tick32 && wd_cnt_q != 6'h00)
      wd_cnt_q <= wd_cnt_q - 6'h01;
  end

  // ----------------------------------------------------------------------------
  // alarm compare, once per second update
  // ----------------------------------------------------------------------------
  assign fld_s = alm_q[0][`RTC_ALM_MATCH] || (alm_q[0][6:0] == time_sec);
  assign fld_m = alm_q[1][`RTC_ALM_MATCH] || (alm_q[1][6:0] == time_min);
  assign fld_h = alm_q[2][`RTC_ALM_MATCH] || (alm_q[2][6:0] == time_hour);
  assign fld_d = alm_q[3][`RTC_ALM_MATCH] || (alm_q[3][6:0] == time_date);
  assign alarm_hit = sec_tick && fld_s && fld_m && fld_h && fld_d;

  // ----------------------------------------------------------------------------
  // flags: a set in the clearing cycle wins
  // ----------------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      wdf_q  <= 1'b0;
      af_q   <= 1'b0;
      oscillator_failed_flag_q <= 1'b0;
    end else begin
      wdf_q  <= wd_fire | (wdf_q & ~rd_clr);
      af_q   <= alarm_hit | (af_q & ~rd_clr);
      oscillator_failed_flag_q <= osc_fail | (oscillator_failed_flag_q & ~rd_clr &
                ~(wr_end && waddr_q == `RTC_A_FLAGS && !wdat_q[`RTC_F_OSCILLATOR_FAILED_FLAG]));
    end
  end

  // ----------------------------------------------------------------------------
  // interrupt pin, active high level; test mode overrides the sources
  // ----------------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst)
      int_out <= 1'b0;
    else if (caltst_q)
      int_out <= tst_512;
    else
      int_out <= (wdf_q & intr_q[`RTC_I_WIE - 2]) |
                 (af_q & intr_q[`RTC_I_AIE - 2]);
  end
endmodule // rtc_top

//--- src/rtc_map.vh
/*
  Register map, field positions and timing constants of the clock support block.
  Assumes a 20 MHz system clock and a 32.768 kHz crystal on the oscillator pin.
*/
`ifndef RTC_MAP_VH
`define RTC_MAP_VH

// ----------------------------------------------------------------------------
// register byte addresses on the 17-bit address pins
// ----------------------------------------------------------------------------
`define RTC_A_FLAGS    17'h1fff0
`define RTC_A_ALM_SEC  17'h1fff2
`define RTC_A_ALM_MIN  17'h1fff3
`define RTC_A_ALM_HR   17'h1fff4
`define RTC_A_ALM_DATE 17'h1fff5
`define RTC_A_INTR     17'h1fff6
`define RTC_A_WDOG     17'h1fff7
`define RTC_A_CAL      17'h1fff8

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define RTC_F_WDF      7
`define RTC_F_AF       6
`define RTC_F_OSCILLATOR_FAILED_FLAG     4
`define RTC_F_CAL      2
`define RTC_F_WHOLD    1
`define RTC_F_RHOLD    0
`define RTC_W_STROBE   7
`define RTC_W_LOCK     6
`define RTC_C_OSCDIS   7
`define RTC_C_SIGN     5
`define RTC_I_WIE      7
`define RTC_I_AIE      6
`define RTC_ALM_MATCH  7

// ----------------------------------------------------------------------------
// oscillator divider figures
// ----------------------------------------------------------------------------
`define RTC_SEC_TERM   16'h7fff
`define RTC_CAL_SHORT  16'h0080
`define RTC_CAL_LONG   16'h0100
`define RTC_MIN_LAST   6'h3b
`define RTC_TICK32_SEL 10'h3ff
`define RTC_TST_BIT    5

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define RTC_CLK_HZ         20000000
`define RTC_CLK_MHZ        20
`define RTC_OSC_CHK_NS     61035
`define RTC_OSC_CHK_CYC    ((`RTC_OSC_CHK_NS * `RTC_CLK_MHZ + 999) / 1000)
`define RTC_OSC_START_S    10
`define RTC_OSC_START_CYC  (`RTC_OSC_START_S * `RTC_CLK_HZ)

`endif

//--- src/rtc_sync.v
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes the inputs are quasi-static levels; no bus coherency is promised.
*/
module rtc_sync #(
  parameter         W    = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input  wire         clk,
  input  wire         srst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_q;

  // ----------------------------------------------------------------------------
  // first stage feeds only the second
  // ----------------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      meta_q <= INIT;
      q      <= INIT;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // rtc_sync

//--- src/rtc_prescale.v
/*
  Oscillator prescaler: free binary chain for the 32 Hz and 512 Hz taps, and a
  calibrated seconds divider with a 64-minute correction cycle.
  Assumes osc_tick is one clk pulse per oscillator rising edge.
*/
`include "rtc_map.vh"

module rtc_prescale (
  input  wire       clk,
  input  wire       srst,
  input  wire       osc_tick,
  input  wire       cal_sign,
  input  wire [4:0] cal_mag,
  output reg        sec_tick,
  output reg        tick32,
  output reg        tst_512
);
  reg  [14:0] free_q;
  reg  [15:0] sec_cnt_q;
  reg  [5:0]  sec_in_min_q;
  reg  [5:0]  min64_q;
  wire        adj_min;
  wire [15:0] sec_term;

  // correction only in second 0 of the first 2N minutes
  assign adj_min  = (sec_in_min_q == 6'h00) && (min64_q < {cal_mag, 1'b0});
  // positive shortens by 128, negative lengthens by 256
  assign sec_term = !adj_min ? `RTC_SEC_TERM :
                    cal_sign ? (`RTC_SEC_TERM - `RTC_CAL_SHORT) :
                               (`RTC_SEC_TERM + `RTC_CAL_LONG);

  // ----------------------------------------------------------------------------
  // free chain: test tap is untouched by calibration
  // ----------------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      free_q  <= 15'h0000;
      tick32  <= 1'b0;
      tst_512 <= 1'b0;
    end else begin
      tick32  <= osc_tick && (free_q[9:0] == `RTC_TICK32_SEL);
      tst_512 <= free_q[`RTC_TST_BIT];
      if (osc_tick)
        free_q <= free_q + 15'h0001;
    end
  end

  // ----------------------------------------------------------------------------
  // seconds divider, minute and 64-minute counters
  // ----------------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      sec_cnt_q    <= 16'h0000;
      sec_in_min_q <= 6'h00;
      min64_q      <= 6'h00;
      sec_tick     <= 1'b0;
    end else begin
      sec_tick <= 1'b0;
      if (osc_tick) begin
        if (sec_cnt_q >= sec_term) begin
          sec_cnt_q <= 16'h0000;
          sec_tick  <= 1'b1;
          if (sec_in_min_q == `RTC_MIN_LAST) begin
            sec_in_min_q <= 6'h00;
            min64_q      <= min64_q + 6'h01;
          end else begin
            sec_in_min_q <= sec_in_min_q + 6'h01;
          end
        end else begin
          sec_cnt_q <= sec_cnt_q + 16'h0001;
        end
      end
    end
  end
endmodule // rtc_prescale

//--- bench/rtc_top_sva.sv
/*
  Checker for the clock support block, bound onto rtc_top.
  Assumes pins move just after clk rises and pass two sync flops.
*/
module rtc_top_sva (
  input logic        clk,
  input logic        srst,
  input logic [16:0] addr,
  input logic        e_n,
  input logic        w_n,
  input logic        g_n,
  input logic        dq_oe,
  input logic        osc_in,
  input logic        oscillator_disable,
  input logic [7:0]  cal_image,
  input logic        sec_tick,
  input logic        write_hold,
  input logic        base_xfer,
  input logic        base_reload
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // cycles since the last oscillator rise, saturating
  logic       osc_d_q;
  logic [3:0] age_q;
  always_ff @(posedge clk) begin
    osc_d_q <= osc_in;
    if (srst || (osc_in && !osc_d_q))
      age_q <= 4'h0;
    else if (age_q != 4'hf)
      age_q <= age_q + 4'h1;
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_dis_from_cal: assert property (oscillator_disable == cal_image[7])
    else $error("disable output differs from stored bit");
  a_reload_enabled: assert property (base_reload |-> !$past(oscillator_disable))
    else $error("reload while oscillator disabled");
  a_reload_keeps_cal: assert property (base_reload |-> $stable(cal_image))
    else $error("calibration changed on failure");
  a_reload_one_pulse: assert property (base_reload |=> !base_reload)
    else $error("reload pulse too long");
  a_xfer_on_fall: assert property ($fell(write_hold) |=> base_xfer)
    else $error("no transfer after hold cleared");
  a_xfer_has_cause: assert property (base_xfer |-> $past(write_hold, 2) && !$past(write_hold))
    else $error("transfer without hold release");
  a_oe_read_only: assert property (dq_oe |-> !$past(e_n, 2) && $past(w_n, 2) && !$past(g_n, 2))
    else $error("data driven outside a read");
  a_oe_mapped: assert property (dq_oe |-> $past(addr, 2) inside {17'h1fff0, [17'h1fff2:17'h1fff8]})
    else $error("data driven for unmapped address");
  a_sec_needs_osc: assert property (sec_tick |-> age_q < 4'h8)
    else $error("second tick without oscillator");
endmodule // rtc_top_sva

bind rtc_top rtc_top_sva u_chk (.clk, .srst, .addr, .e_n, .w_n, .g_n, .dq_oe, .osc_in,
  .oscillator_disable, .cal_image, .sec_tick, .write_hold, .base_xfer, .base_reload);

//--- bench/rtc_host.sv
/*
  Host processor model on the asynchronous byte bus.
  Assumes clk is the block clock; every strobe and address state is held 4 clk or more.
*/
module rtc_host (
  input  logic        clk,
  output logic [16:0] addr,
  output logic [7:0]  dq_in,
  output logic        e_n,
  output logic        w_n,
  output logic        g_n,
  input  logic [7:0]  dq_out,
  input  logic        dq_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus at time zero
  initial begin
    addr  = 17'h00000;
    dq_in = 8'h00;
    e_n   = 1'b1;
    w_n   = 1'b1;
    g_n   = 1'b1;
  end

  // byte write; data outlives the strobe so the synced copy is whole
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    dq_in <= d;
    e_n   <= 1'b0;
    w_n   <= 1'b0;
    repeat (4) @(posedge clk);
    e_n <= 1'b1;
    w_n <= 1'b1;
    // one edge past the commit so callers see the updated register
    repeat (4) @(posedge clk);
    dq_in <= ~d;  // released lines: no pull, so never the old value
  endtask

  // complete read with write enable high throughout
  task automatic rd(input logic [16:0] a, output logic [7:0] d, output logic oe);
    @(posedge clk);
    addr <= a;
    e_n  <= 1'b0;
    g_n  <= 1'b0;
    repeat (5) @(posedge clk);
    d  = dq_out;
    oe = dq_oe;
    e_n <= 1'b1;
    g_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
endmodule // rtc_host

//--- bench/rtc_osc_cal_alarm_watchdog_tb_top.sv
/*
  Self-checking bench for rtc_top with a host model on the bus.
  Assumes a fast stand-in oscillator: one rise every 4 clk.
*/
`include "rtc_map.vh"

module rtc_osc_cal_alarm_watchdog_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        osc_run = 1'b0;
  logic [1:0]  oc_q = 2'h0;
  logic [7:0]  nv_cal = 8'h25;
  logic [7:0]  nv_wdog = 8'h02;
  logic [27:0] now_q = 28'h0200000;  // date, hour, minute, second of the counters
  logic [16:0] addr;
  logic [7:0]  dq_in, dq_out, cal_image, rv;
  logic        e_n, w_n, g_n, dq_oe, osc_dis, wr_hold, int_out, reload, oe;
  int          n_errors = 0;
  int          n_tests = 0;
  int          n_reload = 0;

  // ------------------------------------------------------------
  // clock, oscillator, instances
  // ------------------------------------------------------------
  always #25 clk = ~clk;
  // crystal stand-in stops while the disable bit is set
  always @(posedge clk) begin
    if (osc_run && !osc_dis) oc_q <= oc_q + 2'h1;
    if (reload) n_reload++;
  end

  rtc_top #(.CHK_CYC(100), .START_MAX_CYC(2000)) DUT (
    .clk, .srst, .addr, .dq_in, .dq_out, .dq_oe, .e_n, .w_n, .g_n,
    .osc_in(oc_q[1]), .oscillator_disable(osc_dis), .nv_cal, .nv_wdog, .cal_image,
    .time_sec(now_q[6:0]), .time_min(now_q[13:7]), .time_hour(now_q[20:14]),
    .time_date(now_q[27:21]),
    .sec_tick(), .upd_hold(), .write_hold(wr_hold), .base_xfer(), .base_reload(reload),
    .int_out);
  rtc_host host (.clk, .addr, .dq_in, .e_n, .w_n, .g_n, .dq_out, .dq_oe);

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic do_reset(input logic run);
    @(posedge clk);
    osc_run <= run;
    srst    <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // dead oscillator at power-up, then flag handling
  task automatic t_osc_fail;
    do_reset(1'b0);
    repeat (150) @(posedge clk);
    chk(8'(n_reload), 8'h01);
    chk(cal_image, 8'h25);
    host.wr(`RTC_A_FLAGS, 8'h10);  // a one written is no clear
    host.rd(`RTC_A_FLAGS, rv, oe);
    chk(rv & 8'h10, 8'h10);
    host.rd(`RTC_A_FLAGS, rv, oe);
    chk(rv & 8'h10, 8'h00);
    do_reset(1'b0);
    repeat (150) @(posedge clk);
    host.wr(`RTC_A_FLAGS, 8'h00);
    host.rd(`RTC_A_FLAGS, rv, oe);
    chk(rv & 8'h10, 8'h00);
  endtask

  // test output counted over exactly four of its periods
  task automatic t_test_out;
    int   n;
    logic last;
    do_reset(1'b1);
    chk({7'h00, osc_dis}, 8'h00);
    host.rd(17'h1fff1, rv, oe);
    chk({7'h00, oe}, 8'h00);
    for (int c = 0; c < 2; c++) begin
      host.wr(`RTC_A_CAL, c ? 8'h7f : 8'h25);
      host.rd(`RTC_A_CAL, rv, oe);
      chk(rv, c ? 8'h3f : 8'h25);
      host.wr(`RTC_A_FLAGS, 8'h04);
      n = 0;
      last = int_out;
      repeat (1024) begin
        @(posedge clk);
        if (int_out && !last) n++;
        last = int_out;
      end
      chk(8'(n), 8'h04);
    end
    host.wr(`RTC_A_FLAGS, 8'h00);
  endtask

  // strobes hold off expiry; then it fires; stopped or zero never fires
  task automatic t_watchdog;
    do_reset(1'b1);
    host.wr(`RTC_A_INTR, 8'h80);
    repeat (3) begin
      repeat (3000) @(posedge clk);
      host.wr(`RTC_A_WDOG, 8'h82);
    end
    host.rd(`RTC_A_FLAGS, rv, oe);
    chk(rv & 8'h80, 8'h00);
    repeat (8400) @(posedge clk);
    chk({7'h00, int_out}, 8'h01);
    host.rd(`RTC_A_FLAGS, rv, oe);
    chk(rv & 8'h80, 8'h80);
    repeat (3) @(posedge clk);
    chk({7'h00, int_out}, 8'h00);
    for (int c = 0; c < 2; c++) begin
      host.wr(`RTC_A_CAL, c ? 8'h25 : 8'ha5);
      host.wr(`RTC_A_WDOG, c ? 8'h80 : 8'h82);
      chk({7'h00, osc_dis}, c ? 8'h00 : 8'h01);
      repeat (9000) @(posedge clk);
      host.rd(`RTC_A_FLAGS, rv, oe);
      chk(rv & 8'h80, 8'h00);
    end
  endtask

  // write lock refuses the timeout field but not the lock bit
  task automatic t_lock;
    host.wr(`RTC_A_WDOG, 8'h45);
    host.wr(`RTC_A_WDOG, 8'h03);
    host.rd(`RTC_A_WDOG, rv, oe);
    chk(rv & 8'h3f, 8'h05);
    host.wr(`RTC_A_WDOG, 8'h03);
    host.rd(`RTC_A_WDOG, rv, oe);
    chk(rv & 8'h3f, 8'h03);
  endtask

  task automatic t_hold;
    host.wr(`RTC_A_FLAGS, 8'h02);
    chk({7'h00, wr_hold}, 8'h01);
    host.wr(`RTC_A_FLAGS, 8'h00);
    chk({7'h00, wr_hold}, 8'h00);
  endtask

  // alarm fields keep their match bit; a matching time with no second update
  // must neither set the flag nor drive the pin
  task automatic t_alarm;
    host.wr(`RTC_A_INTR, 8'h40);
    host.wr(`RTC_A_ALM_SEC, 8'h30);
    host.wr(`RTC_A_ALM_DATE, 8'h81);
    host.rd(`RTC_A_ALM_SEC, rv, oe);
    chk(rv, 8'h30);
    host.rd(`RTC_A_ALM_DATE, rv, oe);
    chk(rv, 8'h81);
    now_q <= 28'h0200030;
    repeat (2000) @(posedge clk);
    chk({7'h00, int_out}, 8'h00);
    host.rd(`RTC_A_FLAGS, rv, oe);
    chk(rv & 8'h40, 8'h00);
  endtask

  // ------------------------------------------------------------
  // main sequence and hang guard
  // ------------------------------------------------------------
  initial begin
    t_osc_fail();
    t_test_out();
    t_watchdog();
    t_lock();
    t_hold();
    t_alarm();
    complete_run();
  end

  initial begin
    #(60000 * 50);
    n_errors++;
    complete_run();
  end
endmodule // rtc_osc_cal_alarm_watchdog_tb_top
